// ### rtc_core.sv
// register and timekeeping core of the serial rtc
// What this block does
// - access opens with start and slave address; this core only answers as slave.
// - each further data byte moves the pointer to the next location until stop.
// - below the power-fail threshold all register access is blocked; time keeps running.
// - time at 00h-06h, control at 07h, charger 08h, flag 09h.
// - in block transfers the pointer goes from 07h back to zero.
// - 08h and 09h only by loading the pointer; after 09h back to zero.
// - start, stop and pointer reaching zero copy live time into read buffers.
// - time and calendar count and are accessed in bcd with their ranges.
// - day of week counts 01 to 07 at midnight.
// - date rollover honours month length and leap february.
// - bit 7 of seconds stops the oscillator when 1; resets to 0.
// - century bit inverts on year 99 to 00 when toggle enable is set.
// - writing seconds resets the divider chain.
// - a written byte lands in its register on the acknowledge strobe.
// - with test select 0 the pin shows control bit 7, reset 1.
// - test select 1 gives a 512 hz square wave; reset 0.
// - control bit 5 is calibration sign, 1 faster; reset 0.
// - control bits 4-0 are calibration magnitude 0-31; reset 0.
// - 64 minute cycle; first 2*magnitude minutes get one adjusted second.
// - writing control resets the divider chain.
// - charger on only with key 1010 in bits 7-4; off at reset.
// - bits 3-2 pick diode: 01 none, 10 one.
// - bits 1-0 pick series resistor.
// - stop flag sets when oscillator stops, clears only by writing 0.
`timescale 1ns/1ps
`default_nettype none

module rtc_core
  import rtc_pkg::*;
#(
  parameter int unsigned OSC_DEAD_LIM = OSC_DEAD_CYC
)
(
  input wire logic clk,
  input wire logic rst,
  input wire rtc_req_s req,
  input wire logic below_power_fail_threshold,
  input wire logic osc_pin,
  output logic bus_ready,
  output logic [7:0] rd_data,
  output logic test_output_pin_o,
  output logic test_output_pin_oe_n,
  output rtc_chg_s charger
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9)
      return {v[7:4] + 4'h1, 4'h0};
    return v + 8'h01;
  endfunction : bcd_inc

  function automatic logic [5:0] month_len(input logic [4:0] m, input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    case (m)
      5'h02: return leap ? DOM_FEB_LEAP : DOM_FEB;
      5'h04, 5'h06, 5'h09, 5'h11: return DOM_SHORT;
      default: return DOM_LONG;
    endcase
  endfunction : month_len

  localparam logic [15:0] DEAD_LIM = 16'(OSC_DEAD_LIM);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic pf_m, pf_s, osc_m, osc_s, osc_d;
  logic [7:0] seconds_and_osc_disable, minutes, century_and_hours, day_of_week;
  logic [7:0] day_of_month, month_of_year, year_of_century;
  logic [7:0] output_and_calibration_control, charger_configuration;
  logic osc_stopped_flag;
  logic [3:0] ptr;
  logic [6:0][7:0] snap;
  logic [15:0] div, idle_cnt;
  logic [CAL_W-1:0] cal_min;
  logic [4:0] tone_cnt;
  logic tone_phase, run_d;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // two flops each, plus a third on the crystal for edge detection; the first is read by the second only
  always_ff @(posedge clk)
  begin
    pf_m <= below_power_fail_threshold;
    pf_s <= pf_m;
    osc_m <= osc_pin;
    osc_s <= osc_m;
    osc_d <= osc_s;
  end

  // ----------------------------------------
  // access decode
  // ----------------------------------------
  // access gate and pointer stepping
  wire acc = ~pf_s;
  wire osc_edge = osc_s & ~osc_d;
  wire step = acc & (req.wr | req.rd_adv) & ~req.ptr_load;
  wire ptr_wrap = (ptr == A_CTRL) || (ptr >= A_FLAG);
  wire [3:0] next_ptr = ptr_wrap ? A_SEC : ptr + 4'h1;
  wire wr_en = acc & req.wr & ~req.ptr_load;
  wire we_sec = wr_en && ptr == A_SEC;
  wire we_min = wr_en && ptr == A_MIN;
  wire we_hr = wr_en && ptr == A_HR;
  wire we_dow = wr_en && ptr == A_DOW;
  wire we_dom = wr_en && ptr == A_DOM;
  wire we_mon = wr_en && ptr == A_MON;
  wire we_yr = wr_en && ptr == A_YR;
  wire we_ctrl = wr_en && ptr == A_CTRL;
  wire we_chg = wr_en && ptr == A_CHG;
  wire we_flag = wr_en && ptr == A_FLAG;
  // start or stop opens a new snapshot
  wire snap_take = acc & (req.start | req.stop | (step & next_ptr == A_SEC));

  // ----------------------------------------
  // control fields
  // ----------------------------------------
  wire osc_disable_bit = seconds_and_osc_disable[B_OSC_DIS];
  wire century_toggle_enable = century_and_hours[B_CEN_EN];
  wire century_bit = century_and_hours[B_CEN];
  wire freq_test_select = output_and_calibration_control[B_TEST_SEL];
  wire cal_sign = output_and_calibration_control[B_SIGN];
  wire [4:0] trim_magnitude = output_and_calibration_control[4:0];

  // ----------------------------------------
  // oscillator state
  // ----------------------------------------
  wire dead = idle_cnt == DEAD_LIM;
  wire run = ~osc_disable_bit & ~dead;

  // clk cycles since the last oscillator edge, saturating
  always_ff @(posedge clk)
  begin
    if (rst || osc_edge)
      idle_cnt <= 16'h0000;
    else if (!dead)
      idle_cnt <= idle_cnt + 16'h0001;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      run_d <= 1'b0;
    else
      run_d <= run;
  end

  // ----------------------------------------
  // divider and calibration
  // ----------------------------------------
  // adjusted second: seconds 00 of the first 2*magnitude minutes
  wire cal_sec = (cal_min < {trim_magnitude, 1'b0}) && seconds_and_osc_disable[6:0] == 7'h00;
  wire [15:0] sec_len = !cal_sec ? LEN_M1 : (cal_sign ? LEN_POS_M1 : LEN_NEG_M1);
  wire sec_tick = osc_edge & run & (div >= sec_len);
  wire div_clear = we_sec | we_ctrl;

  always_ff @(posedge clk)
  begin
    if (rst || div_clear)
      div <= 16'h0000;
    else if (osc_edge && run)
      div <= sec_tick ? 16'h0000 : div + 16'h0001;
  end

  // ----------------------------------------
  // rollover chain
  // ----------------------------------------
  wire [5:0] dom_top = month_len(month_of_year[4:0], year_of_century);
  wire c_min = sec_tick && {1'b0, seconds_and_osc_disable[6:0]} == SEC_MAX;
  wire c_hr = c_min && {1'b0, minutes[6:0]} == SEC_MAX;
  wire c_day = c_hr && {2'b00, century_and_hours[5:0]} == HR_MAX;
  wire c_mon = c_day && day_of_month[5:0] == dom_top;
  wire c_yr = c_mon && month_of_year[4:0] == MON_MAX;
  wire c_cen = c_yr && year_of_century == YR_MAX;
  wire [7:0] n_sec = c_min ? 8'h00 : bcd_inc({1'b0, seconds_and_osc_disable[6:0]});
  wire [7:0] n_min = c_hr ? 8'h00 : bcd_inc({1'b0, minutes[6:0]});
  wire [7:0] n_hr = c_day ? 8'h00 : bcd_inc({2'b00, century_and_hours[5:0]});
  wire [2:0] n_dow = day_of_week[2:0] >= DOW_MAX ? 3'h1 : day_of_week[2:0] + 3'h1;
  wire [7:0] n_dom = c_mon ? 8'h01 : bcd_inc({2'b00, day_of_month[5:0]});
  wire [7:0] n_mon = c_yr ? 8'h01 : bcd_inc({3'b000, month_of_year[4:0]});
  wire [7:0] n_yr = c_cen ? 8'h00 : bcd_inc(year_of_century);

  // ----------------------------------------
  // time registers
  // ----------------------------------------
  // seconds with oscillator disable
  always_ff @(posedge clk)
  begin
    if (rst)
      seconds_and_osc_disable <= RST_SEC;
    else if (we_sec)
      seconds_and_osc_disable <= req.data;
    else if (sec_tick)
      seconds_and_osc_disable[6:0] <= n_sec[6:0];
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      minutes <= RST_MIN;
    else if (we_min)
      minutes <= req.data;
    else if (c_min)
      minutes[6:0] <= n_min[6:0];
  end

  // hours plus century toggle
  always_ff @(posedge clk)
  begin
    if (rst)
      century_and_hours <= RST_HR;
    else if (we_hr)
      century_and_hours <= req.data;
    else
    begin
      if (c_hr)
        century_and_hours[5:0] <= n_hr[5:0];
      if (c_cen && century_toggle_enable)
        century_and_hours[B_CEN] <= ~century_bit;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      day_of_week <= RST_DOW;
    else if (we_dow)
      day_of_week <= req.data;
    else if (c_day)
      day_of_week[2:0] <= n_dow;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      day_of_month <= RST_DOM;
    else if (we_dom)
      day_of_month <= req.data;
    else if (c_day)
      day_of_month[5:0] <= n_dom[5:0];
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      month_of_year <= RST_MON;
    else if (we_mon)
      month_of_year <= req.data;
    else if (c_mon)
      month_of_year[4:0] <= n_mon[4:0];
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      year_of_century <= RST_YR;
    else if (we_yr)
      year_of_century <= req.data;
    else if (c_yr)
      year_of_century <= n_yr;
  end

  // minute position in the calibration cycle
  always_ff @(posedge clk)
  begin
    if (rst)
      cal_min <= '0;
    else if (c_min)
      cal_min <= cal_min + 1'b1;
  end

  // ----------------------------------------
  // special registers
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
      output_and_calibration_control <= RST_CTRL;
    else if (we_ctrl)
      output_and_calibration_control <= req.data;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      charger_configuration <= RST_CHG;
    else if (we_chg)
      charger_configuration <= req.data;
  end

  // stop flag: the set wins over a clearing write
  always_ff @(posedge clk)
  begin
    if (rst)
      osc_stopped_flag <= RST_FLAG;
    else if (run_d && !run)
      osc_stopped_flag <= 1'b1;
    else if (we_flag && !req.data[7])
      osc_stopped_flag <= 1'b0;
  end

  // ----------------------------------------
  // pointer and read buffers
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
      ptr <= A_SEC;
    else if (acc && req.ptr_load)
      ptr <= req.data[3:0];
    else if (step)
      ptr <= next_ptr;
  end

  wire [6:0][7:0] live = {year_of_century, month_of_year, day_of_month,
                          day_of_week, century_and_hours, minutes,
                          seconds_and_osc_disable};

  always_ff @(posedge clk)
  begin
    if (rst)
      snap <= '0;
    else if (snap_take)
      snap <= live;
  end

  // read selection: time from buffers, rest live
  wire [7:0] rd_sel = ptr < A_CTRL ? snap[ptr[2:0]] :
                      ptr == A_CTRL ? output_and_calibration_control :
                      ptr == A_CHG ? charger_configuration :
                      ptr == A_FLAG ? {osc_stopped_flag, 7'h00} : 8'h00;

  always_ff @(posedge clk)
  begin
    if (rst)
      rd_data <= 8'h00;
    else
      rd_data <= acc ? rd_sel : 8'h00;
  end

  assign bus_ready = acc;

  // ----------------------------------------
  // test output pin
  // ----------------------------------------
  // tone counter ignores calibration and divider resets
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tone_cnt <= 5'h00;
      tone_phase <= 1'b0;
    end
    else if (osc_edge && !osc_disable_bit)
    begin
      tone_cnt <= tone_cnt + 5'h01;
      if (tone_cnt == TONE_TOP)
        tone_phase <= ~tone_phase;
    end
  end

  // open drain: released for a high level
  wire pin_level = freq_test_select ? tone_phase : output_and_calibration_control[B_OUT];

  always_ff @(posedge clk)
  begin
    if (rst)
      test_output_pin_oe_n <= RST_CTRL[B_OUT];
    else
      test_output_pin_oe_n <= pin_level;
  end

  assign test_output_pin_o = 1'b0;

  // ----------------------------------------
  // charger select
  // ----------------------------------------
  wire [1:0] dsel = charger_configuration[3:2];
  wire chg_on = charger_configuration[7:4] == CHG_KEY
                && (dsel == DIODE_NONE || dsel == DIODE_ONE)
                && charger_configuration[1:0] != RES_OFF;

  always_ff @(posedge clk)
  begin
    if (rst)
      charger <= '0;
    else
      charger <= '{enable: chg_on, diode_choice: dsel,
                   resistor_pick: charger_configuration[1:0]};
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb_main @(posedge clk);
  endclocking
  default disable iff (rst);

  a_ptr_step_next: assert property (step && ptr < A_CTRL |=> ptr == $past(ptr) + 4'h1)
    else $error("pointer did not advance");
  a_ptr_wrap_ctrl: assert property (step && ptr == A_CTRL |=> ptr == A_SEC)
    else $error("pointer did not wrap after control");
  a_ptr_wrap_flag: assert property (step && ptr == A_FLAG |=> ptr == A_SEC)
    else $error("pointer did not wrap after flag");
  a_block_access: assert property (pf_s |=> $stable(ptr) && $stable(charger_configuration)
                                   && $stable(output_and_calibration_control) && rd_data == 8'h00)
    else $error("access while power failed");
  a_div_clear: assert property (we_sec || we_ctrl |=> div == 16'h0000)
    else $error("divider not reset by write");
  a_snap_copy: assert property (acc && req.start |=> snap == $past(live))
    else $error("snapshot not taken on start");
  a_flag_sticky: assert property (osc_stopped_flag && !(we_flag && !req.data[7]) |=> osc_stopped_flag)
    else $error("stop flag lost");
  a_flag_low_zero: assert property (acc && ptr == A_FLAG |=> rd_data[6:0] == 7'h00)
    else $error("flag low bits not zero");
  a_out_follow: assert property (we_ctrl && !req.data[B_TEST_SEL] |-> ##2 test_output_pin_oe_n == $past(req.data[B_OUT], 2))
    else $error("pin does not follow output bit");
  a_charger_key: assert property (we_chg && req.data == 8'ha5 |-> ##2 charger.enable)
    else $error("charger not enabled by key");
  a_sec_roll: assert property (sec_tick && !we_sec && seconds_and_osc_disable[6:0] == 7'h59 |=> seconds_and_osc_disable[6:0] == 7'h00)
    else $error("seconds did not roll");

  c_wrap_ctrl: cover property (step && ptr == A_CTRL ##1 ptr == A_SEC);
  c_tone_on: cover property (freq_test_select && $changed(test_output_pin_oe_n));
  c_flag_clear: cover property (osc_stopped_flag ##1 !osc_stopped_flag);

endmodule : rtc_core

`default_nettype wire

// ### rtc_pkg.sv
// constants and carrier types of the rtc register core
package rtc_pkg;

  // ----------------------------------------
  // register locations
  // ----------------------------------------
  localparam logic [3:0] A_SEC = 4'h0;
  localparam logic [3:0] A_MIN = 4'h1;
  localparam logic [3:0] A_HR = 4'h2;
  localparam logic [3:0] A_DOW = 4'h3;
  localparam logic [3:0] A_DOM = 4'h4;
  localparam logic [3:0] A_MON = 4'h5;
  localparam logic [3:0] A_YR = 4'h6;
  localparam logic [3:0] A_CTRL = 4'h7;
  localparam logic [3:0] A_CHG = 4'h8;
  localparam logic [3:0] A_FLAG = 4'h9;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int B_OSC_DIS = 7;
  localparam int B_CEN_EN = 7;
  localparam int B_CEN = 6;
  localparam int B_OUT = 7;
  localparam int B_TEST_SEL = 6;
  localparam int B_SIGN = 5;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] RST_SEC = 8'h00;
  localparam logic [7:0] RST_MIN = 8'h00;
  localparam logic [7:0] RST_HR = 8'h00;
  localparam logic [7:0] RST_DOW = 8'h01;
  localparam logic [7:0] RST_DOM = 8'h01;
  localparam logic [7:0] RST_MON = 8'h01;
  localparam logic [7:0] RST_YR = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h80;
  localparam logic [7:0] RST_CHG = 8'h00;
  localparam logic RST_FLAG = 1'b1;

  // ----------------------------------------
  // calendar limits and charger codes
  // ----------------------------------------
  localparam logic [7:0] SEC_MAX = 8'h59;
  localparam logic [7:0] HR_MAX = 8'h23;
  localparam logic [2:0] DOW_MAX = 3'h7;
  localparam logic [4:0] MON_MAX = 5'h12;
  localparam logic [7:0] YR_MAX = 8'h99;
  localparam logic [5:0] DOM_LONG = 6'h31;
  localparam logic [5:0] DOM_SHORT = 6'h30;
  localparam logic [5:0] DOM_FEB = 6'h28;
  localparam logic [5:0] DOM_FEB_LEAP = 6'h29;
  localparam logic [3:0] CHG_KEY = 4'ha;
  localparam logic [1:0] DIODE_NONE = 2'h1;
  localparam logic [1:0] DIODE_ONE = 2'h2;
  localparam logic [1:0] RES_OFF = 2'h0;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int OSC_HZ = 32768;
  localparam int TONE_HZ = 512;
  localparam int TONE_HALF = OSC_HZ / (2 * TONE_HZ);
  localparam logic [4:0] TONE_TOP = 5'(TONE_HALF - 1);
  localparam int CAL_NEG = 128;
  localparam int CAL_POS = 256;
  localparam logic [15:0] LEN_M1 = 16'(OSC_HZ - 1);
  localparam logic [15:0] LEN_NEG_M1 = 16'(OSC_HZ + CAL_NEG - 1);
  localparam logic [15:0] LEN_POS_M1 = 16'(OSC_HZ - CAL_POS - 1);
  localparam int CAL_CYCLE_MIN = 64;
  localparam int CAL_W = $clog2(CAL_CYCLE_MIN);
  localparam int OSC_DEAD_US = 100;
  localparam int OSC_DEAD_CYC = OSC_DEAD_US * CLK_MHZ;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic start;
    logic stop;
    logic ptr_load;
    logic wr;
    logic rd_adv;
    logic [7:0] data;
  } rtc_req_s;

  typedef struct packed {
    logic enable;
    logic [1:0] diode_choice;
    logic [1:0] resistor_pick;
  } rtc_chg_s;

endpackage : rtc_pkg

// ### rtc_master_model.sv
// behavioural bus engine and crystal source facing the rtc core
`timescale 1ns/1ps
`default_nettype none

module rtc_master_model
  import rtc_pkg::*;
(
  input wire logic clk,
  input wire logic osc_run,
  output rtc_req_s req,
  output logic osc_pin
);
  // ----------------------------------------
  // crystal: 125 ns period, halts on request
  // ----------------------------------------
  initial osc_pin = 1'b0;
  always
  begin
    #62.5;
    if (osc_run)
      osc_pin = ~osc_pin;
  end

  // ----------------------------------------
  // strobes: one cycle high, then an idle cycle
  // ----------------------------------------
  initial req = '0;
  // idle data shows the inverse of the last byte so stale data never matches
  task automatic pulse(input logic [4:0] k, input logic [7:0] d);
    @(negedge clk);
    req <= {k, d}; // start comes first in each call sequence
    @(negedge clk);
    req <= {5'h00, ~d};
  endtask : pulse
endmodule : rtc_master_model

`default_nettype wire

// ### rtc_core_tb_top.sv
// self-checking bench of the rtc register core
`timescale 1ns/1ps
`default_nettype none

module rtc_core_tb_top
  import rtc_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic pf = 1'b0;
  logic osc_run = 1'b1;
  rtc_req_s req;
  logic osc_pin;
  logic bus_ready;
  logic [7:0] rd_data;
  rtc_chg_s charger;
  logic pin_oe_n;
  logic pin_o;
  int failures = 0;
  int n_compared = 0;
  logic [7:0] expq[$];
  logic [7:0] rnd = 8'h0d;
  logic [7:0] prev;
  logic [7:0] cv[6] = '{8'ha5, 8'hab, 8'ha4, 8'had, 8'h55, 8'ha1};
  logic en;
  int k;
  event look;

  always #5 clk = ~clk;

  rtc_core #(.OSC_DEAD_LIM(64)) rtc_core_inst (
    .clk(clk), .rst(rst), .req(req), .below_power_fail_threshold(pf),
    .osc_pin(osc_pin), .bus_ready(bus_ready), .rd_data(rd_data),
    .test_output_pin_o(pin_o), .test_output_pin_oe_n(pin_oe_n), .charger(charger)
  );

  rtc_master_model rtc_master_model_inst (
    .clk(clk), .osc_run(osc_run), .req(req), .osc_pin(osc_pin)
  );

  // ----------------------------------------
  // compare, verdict, helpers
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out();
    if (failures == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  task automatic wr_seq(input logic [3:0] a, input logic [7:0] d[$]);
    rtc_master_model_inst.pulse(5'h10, 8'h00);
    rtc_master_model_inst.pulse(5'h04, {4'h0, a});
    foreach (d[i])
      rtc_master_model_inst.pulse(5'h02, d[i]);
    rtc_master_model_inst.pulse(5'h08, 8'h00);
  endtask : wr_seq

  // each byte is noted in the queue, then the watcher compares it
  task automatic rd_seq(input logic [3:0] a, input logic [7:0] e[$]);
    rtc_master_model_inst.pulse(5'h10, 8'h00);
    rtc_master_model_inst.pulse(5'h04, {4'h0, a});
    rtc_master_model_inst.pulse(5'h10, 8'h00);
    foreach (e[i])
    begin
      repeat (2) @(posedge clk);
      @(negedge clk);
      expq.push_back(e[i]);
      -> look;
      rtc_master_model_inst.pulse(5'h01, 8'h00);
    end
    rtc_master_model_inst.pulse(5'h08, 8'h00);
  endtask : rd_seq

  // ----------------------------------------
  // result watcher
  // ----------------------------------------
  always @(look)
    check(rd_data, expq.pop_front());

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  initial
  begin
    #500us;
    failures++;
    close_out();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (16) @(negedge clk);
    rst <= 1'b0;
    repeat (4) @(negedge clk);
    // reset map, wrap 07h to 00h
    rd_seq(4'h0, '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h80, 8'h00});
    check({7'h0, pin_oe_n}, 8'h01);
    check({7'h0, pin_o}, 8'h00);
    check({7'h0, charger.enable}, 8'h00);
    // flag: set at power-up, writing 1 keeps it, low bits read 0
    wr_seq(4'h9, '{8'hff});
    rd_seq(4'h9, '{8'h80});
    wr_seq(4'h9, '{8'h00});
    rd_seq(4'h9, '{8'h00});
    // block write of time and calendar in bcd, read back
    wr_seq(4'h0, '{8'h45, 8'h59, 8'ha3, 8'h07, 8'h31, 8'h12, 8'h99});
    rd_seq(4'h0, '{8'h45, 8'h59, 8'ha3, 8'h07, 8'h31, 8'h12, 8'h99, 8'h80});
    // charger codes; 08h steps to 09h then wraps to 00h
    foreach (cv[i])
    begin
      wr_seq(4'h8, '{cv[i]});
      en = (cv[i][7:4] == 4'ha) && (cv[i][3:2] == 2'h1 || cv[i][3:2] == 2'h2)
        && (cv[i][1:0] != 2'h0);
      check({7'h0, charger.enable}, {7'h0, en});
      if (en)
        check({3'h0, charger}, {3'h0, en, cv[i][3:0]});
      rd_seq(4'h8, '{cv[i], 8'h00, 8'h45});
    end
    // random calibration fields with the output bit high
    repeat (3)
    begin
      rnd = lfsr(rnd);
      wr_seq(4'h7, '{{2'b10, rnd[5:0]}});
      rd_seq(4'h7, '{{2'b10, rnd[5:0]}});
      check({7'h0, pin_oe_n}, 8'h01);
    end
    wr_seq(4'h7, '{8'h00});
    check({7'h0, pin_oe_n}, 8'h00);
    // 512 hz tone: half period of 32 crystal edges is 400 clocks
    wr_seq(4'h7, '{8'h40});
    for (int h = 0; h < 2; h++)
    begin
      prev = {7'h0, pin_oe_n};
      k = 0;
      while (pin_oe_n === prev[0] && k < 1000)
      begin
        @(posedge clk);
        k++;
      end
    end
    check({7'h0, k >= 398 && k <= 402}, 8'h01);
    wr_seq(4'h7, '{8'h80});
    // oscillator disable, then a dead crystal, both set the flag
    wr_seq(4'h0, '{8'h80});
    rd_seq(4'h9, '{8'h80});
    wr_seq(4'h0, '{8'h45});
    wr_seq(4'h9, '{8'h00});
    osc_run <= 1'b0;
    repeat (200) @(negedge clk);
    osc_run <= 1'b1;
    rd_seq(4'h9, '{8'h80});
    // power fail blocks access
    pf <= 1'b1;
    repeat (6) @(negedge clk);
    check({7'h0, bus_ready}, 8'h00);
    wr_seq(4'h7, '{8'h00});
    check(rd_data, 8'h00);
    pf <= 1'b0;
    repeat (6) @(negedge clk);
    rd_seq(4'h7, '{8'h80});
    close_out();
  end
endmodule : rtc_core_tb_top

`default_nettype wire
